/* File: subtract_xor_swap_sleep_exec_bench.sv */
`timescale 1ns/10ps
module subtract_xor_swap_sleep_exec_bench;
    import sxs_pkg::*;
    logic mclk = 0, nrst = 0, wake = 0, tick = 0, v = 0, dst = 0, es = 0;
    logic ec = 0, edc = 0, ez = 0, we, tos, pds, slp;
    logic [7:0] lit = 0, ea = 0, rv, acc, rd, pa, pb, pc, wc, pr;
    logic [6:0] ad = 0, rad;
    logic [7:0] ep [3];
    sxs_op_e op = SXS_NOP;
    sxs_flags_s fl;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    always #2 mclk = ~mclk;
    sxs_exec u_sxs_exec (.mclk, .nrst, .instr({v, op, lit, ad, dst, rv}),
        .wake, .wdt_tick(tick), .acc, .flags(fl), .reg_we(we),
        .reg_addr(rad), .reg_wdata(rd), .port_a_direction(pa),
        .port_b_direction(pb), .port_c_direction(pc),
        .timeout_status_bit(tos), .powerdown_status_bit(pds),
        .watchdog_counter(wc), .wdt_prescaler(pr), .asleep(slp));
    sxs_fd_model u_sxs_fd_model (.mclk, .we, .wa(rad), .wd(rd), .ra(ad),
        .rd(rv));
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task rst;
        v = 0;
        nrst = 0;
        repeat (12) @(negedge mclk);
        nrst = 1;
        {ea, ec, edc, ez, es} = '0;
        ep = '{3{8'hff}};
        chk({pa, pb, pc, acc}, 32'hffffff00);
        chk({tos, pds, slp, we}, 4'hc);
    endtask : rst
    task run(input sxs_op_e o, input logic [7:0] k,
             input logic [6:0] a, input logic d);
        logic [8:0] r;
        logic [4:0] h;
        logic b, s, w;
        op = o;
        {lit, ad, dst, v, tick} = {k, a, d, 1'b1, 1'($urandom)};
        // Wait for the file register read of the new address to settle.
        #1;
        if (es) o = SXS_NOP;
        b = o == REG_MINUS_ACC_BORROW_OP && !ec;
        s = o inside {LITERAL_MINUS_ACC_OP, REG_MINUS_ACC_OP,
                      REG_MINUS_ACC_BORROW_OP};
        r = (o == LITERAL_MINUS_ACC_OP ? k : rv) - ea - b;
        h = (o == LITERAL_MINUS_ACC_OP ? k[3:0] : rv[3:0]) - ea[3:0] - b;
        if (s) {ec, edc, ez} = {!r[8], !h[4], r[7:0] == 8'h00};
        if (o == NIBBLE_EXCHANGE_OP) r = {rv[3:0], rv[7:4]};
        if (o == LITERAL_XOR_ACC_OP) r = ea ^ k;
        if (o == REG_XOR_ACC_OP) r = ea ^ rv;
        if (o inside {LITERAL_XOR_ACC_OP, REG_XOR_ACC_OP}) ez = !(|r[7:0]);
        w = d && o inside {REG_MINUS_ACC_OP, REG_MINUS_ACC_BORROW_OP,
                           NIBBLE_EXCHANGE_OP, REG_XOR_ACC_OP};
        if (!w && (s || o inside {NIBBLE_EXCHANGE_OP, LITERAL_XOR_ACC_OP,
            REG_XOR_ACC_OP})) ea = r[7:0];
        if (o == DIRECTION_LOAD_OP && a inside {[5:7]}) ep[a - 5] = ea;
        if (o == SLEEP_OP) es = 1;
        @(negedge mclk);
        chk(acc, ea);
        chk(fl, {ec, edc, ez});
        chk({we, slp}, {w, es});
        if (w) chk({rad, rd}, {a, r[7:0]});
        chk({pa, pb, pc}, {ep[0], ep[1], ep[2]});
    endtask : run
    task close_out;
        $display("mismatches %0d compares %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 2000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        void'($urandom(58));
        rst();
        run(LITERAL_XOR_ACC_OP, 8'h3c, 0, 0);
        run(LITERAL_MINUS_ACC_OP, 8'h3c, 0, 0);
        run(LITERAL_XOR_ACC_OP, 8'h01, 0, 0);
        run(LITERAL_MINUS_ACC_OP, 8'h00, 0, 0);
        run(REG_MINUS_ACC_BORROW_OP, 0, 7'h10, 1);
        for (int i = 4; i < 9; i++) run(DIRECTION_LOAD_OP, 0, 7'(i), 0);
        repeat (400) run(sxs_op_e'(1 + $urandom % 7), 8'($urandom),
            7'($urandom), 1'($urandom));
        run(SLEEP_OP, 0, 0, 0);
        chk({tos, pds, wc, pr}, {2'b10, 16'h0000});
        run(LITERAL_XOR_ACC_OP, 8'h5a, 0, 0);
        v = 0;
        wake = 1;
        @(negedge mclk);
        {wake, es} = 2'b00;
        chk(slp, 0);
        rst();
        run(REG_XOR_ACC_OP, 0, 7'h10, 1);
        close_out();
    end
endmodule : subtract_xor_swap_sleep_exec_bench

/* File: sxs_exec.sv */
`timescale 1ns/10ps
// Behaviour
// (RULE_01) Literal minus accumulator goes to accumulator; carry, digit carry, zero.
// (RULE_02) Carry set when acc <= literal; digit carry same on low nibbles.
// (RULE_03) Sleep clears powerdown status bit and sets timeout status bit.
// (RULE_04) Sleep clears watchdog counter and its prescaler.
// (RULE_05) Sleep halts the processor so instruction execution stops.
// (RULE_06) Register minus accumulator updates carry, digit carry and zero.
// (RULE_07) Register minus accumulator minus inverted carry to selected destination.
// (RULE_08) Destination 0 means accumulator, 1 means addressed file register.
// (RULE_09) Nibble exchange swaps register halves into destination; flags untouched.
// (RULE_10) Literal xor accumulator into accumulator; only zero flag changes.
// (RULE_11) Register xor accumulator to selected destination; only zero flag.
// (RULE_12) Direction load copies accumulator to port A, B, C for 5, 6, 7.
// (RULE_13) Zero flag is one exactly when the eight-bit result is zero.
module sxs_exec
    import sxs_pkg::*;
#(
    parameter int unsigned WDT_W = DATA_W,
    parameter int unsigned PRE_W = DATA_W
) (
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire sxs_instr_s        instr,
    input  wire logic              wake,
    input  wire logic              wdt_tick,
    output logic      [DATA_W-1:0] acc,
    output sxs_flags_s             flags,
    output logic                   reg_we,
    output logic      [ADDR_W-1:0] reg_addr,
    output logic      [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] port_a_direction,
    output logic      [DATA_W-1:0] port_b_direction,
    output logic      [DATA_W-1:0] port_c_direction,
    output logic                   timeout_status_bit,
    output logic                   powerdown_status_bit,
    output logic      [WDT_W-1:0]  watchdog_counter,
    output logic      [PRE_W-1:0]  wdt_prescaler,
    output logic                   asleep
);
    logic [DATA_W-1:0] sub_a;
    logic [DATA_W-1:0] sub_diff;
    logic              sub_borrow;
    logic              sub_carry;
    logic              sub_half;

    logic [DATA_W-1:0] next_acc;
    sxs_flags_s        next_flags;
    logic              next_reg_we;
    logic [ADDR_W-1:0] next_reg_addr;
    logic [DATA_W-1:0] next_reg_wdata;
    logic [DATA_W-1:0] next_dir_a;
    logic [DATA_W-1:0] next_dir_b;
    logic [DATA_W-1:0] next_dir_c;
    logic              next_timeout;
    logic              next_powerdown;
    logic [WDT_W-1:0]  next_wdt;
    logic [PRE_W-1:0]  next_pre;
    logic              next_asleep;

    logic [DATA_W-1:0] result;
    logic              write_result;
    logic              take_arith;
    logic              take_zero;
    logic              go;

    always_comb begin
        sub_a      = instr.reg_value;
        sub_borrow = 1'b0;
        case (instr.op)
            LITERAL_MINUS_ACC_OP: begin
                sub_a = instr.literal; // RULE_01
            end
            REG_MINUS_ACC_BORROW_OP: begin
                sub_borrow = ~flags.carry; // RULE_07
            end
            default: begin
                sub_a = instr.reg_value; // RULE_06
            end
        endcase
    end

    // One shared subtractor serves all three subtract forms.
    sxs_sub #(
        .W (DATA_W)
    ) u_sub (
        .a          (sub_a),
        .b          (acc),
        .borrow_in  (sub_borrow),
        .diff       (sub_diff),
        .carry_out  (sub_carry),
        .half_carry (sub_half)
    );

    always_comb begin
        next_acc       = acc;
        next_flags     = flags;
        next_reg_we    = 1'b0;
        next_reg_addr  = reg_addr;
        next_reg_wdata = reg_wdata;
        next_dir_a     = port_a_direction;
        next_dir_b     = port_b_direction;
        next_dir_c     = port_c_direction;
        next_timeout   = timeout_status_bit;
        next_powerdown = powerdown_status_bit;
        next_wdt       = watchdog_counter;
        next_pre       = wdt_prescaler;
        next_asleep    = asleep;
        result         = sub_diff;
        write_result   = 1'b0;
        take_arith     = 1'b0;
        take_zero      = 1'b0;
        // Nothing executes while asleep; the oscillator is modelled as halted.
        go             = instr.valid && !asleep; // RULE_05

        if (wdt_tick) begin
            next_pre = wdt_prescaler + PRE_W'(1);
            if (&wdt_prescaler) begin
                next_wdt = watchdog_counter + WDT_W'(1);
            end
        end

        if (asleep && wake) begin
            next_asleep = 1'b0;
        end

        if (go) begin
            case (instr.op)
                LITERAL_MINUS_ACC_OP,
                REG_MINUS_ACC_OP,
                REG_MINUS_ACC_BORROW_OP: begin
                    result       = sub_diff;
                    write_result = 1'b1;
                    take_arith   = 1'b1;
                    take_zero    = 1'b1;
                end
                NIBBLE_EXCHANGE_OP: begin
                    result = {instr.reg_value[NIB_W-1:0],
                              instr.reg_value[DATA_W-1:NIB_W]}; // RULE_09
                    write_result = 1'b1;
                end
                LITERAL_XOR_ACC_OP: begin
                    result       = acc ^ instr.literal; // RULE_10
                    write_result = 1'b1;
                    take_zero    = 1'b1;
                end
                REG_XOR_ACC_OP: begin
                    result       = acc ^ instr.reg_value; // RULE_11
                    write_result = 1'b1;
                    take_zero    = 1'b1;
                end
                DIRECTION_LOAD_OP: begin
                    case (instr.addr) // RULE_12
                        DIR_SEL_A: begin
                            next_dir_a = acc;
                        end
                        DIR_SEL_B: begin
                            next_dir_b = acc;
                        end
                        DIR_SEL_C: begin
                            next_dir_c = acc;
                        end
                        default: begin
                            next_dir_a = port_a_direction;
                        end
                    endcase
                end
                SLEEP_OP: begin
                    next_powerdown = 1'b0; // RULE_03
                    next_timeout   = 1'b1; // RULE_03
                    next_wdt       = WDT_W'(WDT_CLEAR); // RULE_04
                    next_pre       = PRE_W'(WDT_CLEAR); // RULE_04
                    next_asleep    = 1'b1; // RULE_05
                end
                default: begin
                    write_result = 1'b0;
                end
            endcase
        end

        if (take_arith) begin
            next_flags.carry            = sub_carry; // RULE_02
            next_flags.digit_carry_flag = sub_half; // RULE_02
        end
        if (take_zero) begin
            next_flags.zero = (result == '0); // RULE_13
        end

        if (write_result) begin
            // Literal forms always land in the accumulator.
            if (instr.op == LITERAL_MINUS_ACC_OP ||
                instr.op == LITERAL_XOR_ACC_OP ||
                instr.dest == DEST_ACC) begin // RULE_08
                next_acc = result;
            end else begin
                next_reg_we    = 1'b1; // RULE_08
                next_reg_addr  = instr.addr;
                next_reg_wdata = result;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            acc                  <= ACC_RST;
            flags                <= '0;
            reg_we               <= 1'b0;
            reg_addr             <= '0;
            reg_wdata            <= '0;
            port_a_direction     <= DIR_RST;
            port_b_direction     <= DIR_RST;
            port_c_direction     <= DIR_RST;
            timeout_status_bit   <= TIMEOUT_RST;
            powerdown_status_bit <= POWERDOWN_RST;
            watchdog_counter     <= '0;
            wdt_prescaler        <= '0;
            asleep               <= 1'b0;
        end else begin
            acc                  <= next_acc;
            flags                <= next_flags;
            reg_we               <= next_reg_we;
            reg_addr             <= next_reg_addr;
            reg_wdata            <= next_reg_wdata;
            port_a_direction     <= next_dir_a;
            port_b_direction     <= next_dir_b;
            port_c_direction     <= next_dir_c;
            timeout_status_bit   <= next_timeout;
            powerdown_status_bit <= next_powerdown;
            watchdog_counter     <= next_wdt;
            wdt_prescaler        <= next_pre;
            asleep               <= next_asleep;
        end
    end

endmodule : sxs_exec

/* File: sxs_exec_props.sv */
`timescale 1ns/10ps
module sxs_exec_props
    import sxs_pkg::*;
#(
    parameter int unsigned WDT_W = DATA_W,
    parameter int unsigned PRE_W = DATA_W
) (
    input wire logic              mclk,
    input wire logic              nrst,
    input wire sxs_instr_s        instr,
    input wire logic [DATA_W-1:0] acc,
    input wire sxs_flags_s        flags,
    input wire logic              reg_we,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] port_b_direction,
    input wire logic              timeout_status_bit,
    input wire logic              powerdown_status_bit,
    input wire logic [WDT_W-1:0]  watchdog_counter,
    input wire logic [PRE_W-1:0]  wdt_prescaler,
    input wire logic              asleep
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // A valid instruction only counts on an edge where the core is awake.
    wire t  = instr.valid && !asleep;
    wire ls = t && instr.op == LITERAL_MINUS_ACC_OP;
    wire sl = t && instr.op == SLEEP_OP;
    property p_slp;
        sl |=> asleep && !powerdown_status_bit && timeout_status_bit
            && watchdog_counter == '0 && wdt_prescaler == '0;
    endproperty
    property p_lit;
        ls |=> acc == 8'($past(instr.literal) - $past(acc))
            && flags.carry == ($past(acc) <= $past(instr.literal));
    endproperty
    property p_dc;
        ls |=> flags.digit_carry_flag
            == ($past(acc[3:0]) <= $past(instr.literal[3:0]));
    endproperty
    property p_sub;
        t && instr.op == REG_MINUS_ACC_OP && !instr.dest
            |=> flags.carry == ($past(acc) <= $past(instr.reg_value));
    endproperty
    property p_dst;
        t && instr.dest && instr.op inside {REG_MINUS_ACC_OP,
            REG_MINUS_ACC_BORROW_OP, NIBBLE_EXCHANGE_OP, REG_XOR_ACC_OP}
            |=> reg_we && reg_addr == $past(instr.addr);
    endproperty
    property p_swp;
        t && instr.op == NIBBLE_EXCHANGE_OP && !instr.dest |=> $stable(flags)
            && acc == {$past(instr.reg_value[3:0]),
                       $past(instr.reg_value[7:4])};
    endproperty
    property p_xl;
        t && instr.op == LITERAL_XOR_ACC_OP |=> acc == ($past(acc)
            ^ $past(instr.literal)) && flags.carry == $past(flags.carry);
    endproperty
    property p_xz;
        t && instr.op == REG_XOR_ACC_OP && !instr.dest
            |=> flags.zero == (acc == 8'h00) && $stable(flags.carry);
    endproperty
    property p_dir;
        t && instr.op == DIRECTION_LOAD_OP && instr.addr == DIR_SEL_B
            |=> port_b_direction == $past(acc);
    endproperty
    a_slp: assert property (p_slp) else $error("sleep entry");
    a_lit: assert property (p_lit) else $error("literal sub");
    a_dc: assert property (p_dc) else $error("digit carry");
    a_sub: assert property (p_sub) else $error("reg sub carry");
    a_dst: assert property (p_dst) else $error("destination");
    a_swp: assert property (p_swp) else $error("nibble swap");
    a_xl: assert property (p_xl) else $error("literal xor");
    a_xz: assert property (p_xz) else $error("xor zero");
    a_dir: assert property (p_dir) else $error("direction b");
    c_slp: cover property (sl);
    c_wr: cover property (reg_we);
    c_wake: cover property (asleep ##1 !asleep);
endmodule : sxs_exec_props

bind sxs_exec sxs_exec_props #(.WDT_W(WDT_W), .PRE_W(PRE_W)) u_props (
    .mclk, .nrst, .instr, .acc, .flags, .reg_we, .reg_addr,
    .port_b_direction, .timeout_status_bit, .powerdown_status_bit,
    .watchdog_counter, .wdt_prescaler, .asleep);

/* File: sxs_fd_model.sv */
`timescale 1ns/10ps
// File registers that decode reads ahead of each instruction.
module sxs_fd_model
    import sxs_pkg::*;
(
    input wire logic              mclk,
    input wire logic              we,
    input wire logic [ADDR_W-1:0] wa,
    input wire logic [DATA_W-1:0] wd,
    input wire logic [ADDR_W-1:0] ra,
    output logic     [DATA_W-1:0] rd
);
    logic [DATA_W-1:0] mem [128];
    initial foreach (mem[i]) mem[i] = 8'(i * 37);
    always @(posedge mclk) if (we) mem[wa] <= wd;
    assign rd = mem[ra];
endmodule : sxs_fd_model

/* File: sxs_pkg.sv */
package sxs_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned NIB_W  = 4;

    // Operand of the direction-load instruction that selects each port.
    localparam logic [ADDR_W-1:0] DIR_SEL_A = 7'h05;
    localparam logic [ADDR_W-1:0] DIR_SEL_B = 7'h06;
    localparam logic [ADDR_W-1:0] DIR_SEL_C = 7'h07;

    // Reset values, and the watchdog clear value loaded by sleep.
    localparam logic [DATA_W-1:0] ACC_RST       = 8'h00;
    localparam logic [DATA_W-1:0] DIR_RST       = 8'hff;
    localparam logic [DATA_W-1:0] WDT_CLEAR     = 8'h00;
    localparam logic              TIMEOUT_RST   = 1'b1;
    localparam logic              POWERDOWN_RST = 1'b1;

    // Destination selector values.
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_REG = 1'b1;

    typedef enum logic [3:0] {
        SXS_NOP,
        LITERAL_MINUS_ACC_OP,
        REG_MINUS_ACC_OP,
        REG_MINUS_ACC_BORROW_OP,
        NIBBLE_EXCHANGE_OP,
        LITERAL_XOR_ACC_OP,
        REG_XOR_ACC_OP,
        DIRECTION_LOAD_OP,
        SLEEP_OP
    } sxs_op_e;

    // One decoded instruction from the fetch and decode stage.
    typedef struct packed {
        logic              valid;
        sxs_op_e           op;
        logic [DATA_W-1:0] literal;
        logic [ADDR_W-1:0] addr;
        logic              dest;
        logic [DATA_W-1:0] reg_value;
    } sxs_instr_s;

    // Arithmetic status flags.
    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } sxs_flags_s;

endpackage : sxs_pkg

/* File: sxs_sub.sv */
`timescale 1ns/10ps
// Subtractor a - b - borrow with carry meaning "no borrow".
module sxs_sub
    import sxs_pkg::*;
#(
    parameter int unsigned W = DATA_W
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    input  wire logic         borrow_in,
    output logic      [W-1:0] diff,
    output logic              carry_out,
    output logic              half_carry
);
    logic [W:0]       full;
    logic [NIB_W:0]   low;

    always_comb begin
        full       = {1'b0, a} + {1'b0, ~b} + {{W{1'b0}}, ~borrow_in};
        low        = {1'b0, a[NIB_W-1:0]} + {1'b0, ~b[NIB_W-1:0]}
                   + {{NIB_W{1'b0}}, ~borrow_in};
        diff       = full[W-1:0];
        carry_out  = full[W];
        half_carry = low[NIB_W];
    end

endmodule : sxs_sub
